// ==== common/dmaeis_pkg.sv ====
// Purpose: shared constants and types of the dma event and interrupt select block
// Assumes: 16-bit data memory mapped registers, one clock
// Notes:   field positions inside the subbank words are local choices
package dmaeis_pkg;
   // ---------------------------------------------------------------
   // register addresses and subbank layout
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_PRIO_EN   = 8'h54;
   localparam logic [7:0] OFF_SUB_PTR   = 8'h55;
   localparam logic [7:0] OFF_SUB_INC   = 8'h56;
   localparam logic [7:0] OFF_SUB_PLAIN = 8'h57;
   localparam int         NUM_CH        = 6;
   localparam int         REGS_PER_CH   = 5;
   localparam int         NUM_SUB       = NUM_CH * REGS_PER_CH;
   localparam int         SUB_ECOUNT    = 2;
   localparam int         SUB_SYNC_FC   = 3;
   localparam int         SUB_MODE      = 4;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int          PREC_ENABLE_LSB = 0;
   localparam int          PREC_PRIO_LSB   = 8;
   localparam int          PREC_ROUTE_LSB  = 14;
   localparam logic [15:0] PREC_RESET      = 16'h0000;
   localparam logic [15:0] SUB_RESET       = 16'h0000;
   localparam int          SFC_SYNC_LSB    = 12;
   localparam int          SFC_FRAME_LSB   = 0;
   localparam int          MODE_ABU_BIT    = 12;
   localparam int          MODE_IEN_BIT    = 13;
   localparam int          MODE_ITIM_BIT   = 14;
   localparam logic [1:0]  ROUTE_PORTS     = 2'h0;
   localparam logic [1:0]  ROUTE_CH23      = 2'h1;
   localparam logic [1:0]  ROUTE_CH0123    = 2'h2;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      SYNC_NONE  = 4'h0,
      SYNC_P0_RX = 4'h1,
      SYNC_P0_TX = 4'h2,
      SYNC_P2_RX = 4'h3,
      SYNC_P2_TX = 4'h4,
      SYNC_P1_RX = 4'h5,
      SYNC_P1_TX = 4'h6,
      SYNC_TIMER = 4'hD,
      SYNC_EXT3  = 4'hE
   } dmaeis_sync_sel_t;
   typedef struct packed {
      logic p0_rx;
      logic p0_tx;
      logic p2_rx;
      logic p2_tx;
      logic p1_rx;
      logic p1_tx;
      logic timer;
      logic ext3;
   } dmaeis_sync_evt_t;
   typedef struct packed {
      logic p2_rx;
      logic p2_tx;
      logic p1_rx;
      logic p1_tx;
   } dmaeis_port_irq_t;
   typedef struct packed {
      logic line6;
      logic line7;
      logic line10;
      logic line11;
   } dmaeis_cpu_line_t;
endpackage : dmaeis_pkg

// ==== rtl/dmaeis_sync_select.sv ====
// Purpose: one channel's sync event selector
// Assumes: event inputs are one-clock pulses on the device clock
// Notes:   reserved codes select nothing
`timescale 1ns/1ns
module dmaeis_sync_select
   import dmaeis_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic [3:0]       sel,
   input  wire dmaeis_sync_evt_t events,
   output logic                  sync_req
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   function automatic logic pick(input logic [3:0] s, input dmaeis_sync_evt_t e);
      case (s)
         SYNC_P0_RX: pick = e.p0_rx;
         SYNC_P0_TX: pick = e.p0_tx;
         SYNC_P2_RX: pick = e.p2_rx;
         SYNC_P2_TX: pick = e.p2_tx;
         SYNC_P1_RX: pick = e.p1_rx;
         SYNC_P1_TX: pick = e.p1_tx;
         SYNC_TIMER: pick = e.timer;
         SYNC_EXT3:  pick = e.ext3;
         default:    pick = 1'b0;
      endcase
   endfunction : pick

   wire logic next_sync_req = pick(sel, events);

   always_ff @(posedge clock) begin
      if (srst) sync_req <= 1'b0;
      else sync_req <= next_sync_req;
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_no_sync;
      @(posedge clock) disable iff (srst) sel == 4'h0 |=> !sync_req;
   endproperty
   a_no_sync: assert property (p_no_sync) else $error("unsynced channel got event");
   property p_port0_rx;
      @(posedge clock) disable iff (srst) sel == 4'h1 |=> sync_req == $past(events.p0_rx);
   endproperty
   a_port0_rx: assert property (p_port0_rx) else $error("port0 rx not selected");
   property p_timer;
      @(posedge clock) disable iff (srst) sel == 4'hD |=> sync_req == $past(events.timer);
   endproperty
   a_timer: assert property (p_timer) else $error("timer event not selected");
endmodule : dmaeis_sync_select

// ==== rtl/dmaeis_top.sv ====
// Purpose: dma event pacing, channel interrupt timing and cpu interrupt routing
// Assumes: cpu data bus strobes and transfer engine pulses share this clock
// Notes:   external interrupt 3 is a pin and is resynchronised here
//
// Operation
// - interrupt enable bit clear means the channel never interrupts.
// - auto-buffer interrupts at full buffer, plus half buffer when timing bit set.
// - multi-frame with timing bit clear interrupts only at block completion.
// - multi-frame with timing bit set interrupts every frame end and block end.
// - four-bit sync select per channel, zero means unsynchronised.
// - codes one to six pick serial port 0, 2, 1 receive and transmit.
// - code D is timer, E external interrupt 3, others reserved.
// - each of the six channels has its own interrupt source.
// - channels 0 to 3 share cpu lines with ports, unrouted after reset.
// - routing 00 puts port 2 and port 1 interrupts on lines 6,7,10,11.
// - routing 01 keeps port 2 on 6,7 and channels 2,3 on 10,11.
// - routing 10 puts channels 0 to 3 on lines 6,7,10,11; 11 reserved.
// - registers at 54h, 55h, 56h and 57h.
// - auto-increment port bumps the subbank pointer, plain port leaves it.
// - element count drops per read, frame count at each multi-frame frame end but the last.
`timescale 1ns/1ns
module dmaeis_top
   import dmaeis_pkg::*;
#(
   parameter int ADDR_W = 16
)(
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire logic [ADDR_W-1:0] mmr_addr,
   input  wire logic              mmr_rd,
   input  wire logic              mmr_wr,
   input  wire logic [15:0]       mmr_wdata,
   output logic [15:0]            mmr_rdata,
   input  wire dmaeis_sync_evt_t  sync_events,
   input  wire logic              ext_irq3_pin,
   input  wire logic [5:0]        xfer_read,
   input  wire dmaeis_port_irq_t  port_irqs,
   output logic [5:0]             sync_req,
   output logic [5:0]             chan_irq,
   output dmaeis_cpu_line_t       cpu_lines,
   output logic [5:0]             chan_enable,
   output logic [5:0]             chan_high_prio
);
   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   logic [15:0] prio_en;
   logic [15:0] sub_ptr;
   logic [15:0] sub [NUM_SUB];
   logic [15:0] len [NUM_CH];
   wire logic       hit_prec  = mmr_addr == ADDR_W'(OFF_PRIO_EN);
   wire logic       hit_ptr   = mmr_addr == ADDR_W'(OFF_SUB_PTR);
   wire logic       hit_inc   = mmr_addr == ADDR_W'(OFF_SUB_INC);
   wire logic       hit_plain = mmr_addr == ADDR_W'(OFF_SUB_PLAIN);
   wire logic       sub_acc   = (hit_inc | hit_plain) & (mmr_rd | mmr_wr);
   wire logic       sub_valid = sub_ptr < 16'(NUM_SUB);
   wire logic [4:0] sub_idx   = sub_ptr[4:0];
   wire logic       sub_wr    = mmr_wr & (hit_inc | hit_plain) & sub_valid;
   wire logic [1:0] route     = prio_en[PREC_ROUTE_LSB +: 2];

   always_ff @(posedge clock) begin
      if (srst) begin
         prio_en <= PREC_RESET;
         sub_ptr <= SUB_RESET;
      end else begin
         if (mmr_wr && hit_prec) prio_en <= mmr_wdata;
         if (mmr_wr && hit_ptr) sub_ptr <= mmr_wdata;
         else if (sub_acc && hit_inc) sub_ptr <= sub_ptr + 16'h0001;
      end
   end

   wire logic [15:0] next_rdata = hit_prec ? prio_en :
                                  hit_ptr  ? sub_ptr :
                                  ((hit_inc | hit_plain) & sub_valid) ? sub[sub_idx] : 16'h0000;
   always_ff @(posedge clock) begin
      if (srst) mmr_rdata <= 16'h0000;
      else if (mmr_rd) mmr_rdata <= next_rdata;
   end

   assign chan_enable    = prio_en[PREC_ENABLE_LSB +: NUM_CH];
   assign chan_high_prio = prio_en[PREC_PRIO_LSB +: NUM_CH];

   // ---------------------------------------------------------------
   // external interrupt 3 resynchroniser
   // ---------------------------------------------------------------
   logic [2:0] ext_sync;
   logic       ext_level;
   logic       ext_level_d;
   always_ff @(posedge clock) begin
      if (srst) begin
         ext_sync    <= 3'h0;
         ext_level   <= 1'b0;
         ext_level_d <= 1'b0;
      end else begin
         ext_sync    <= {ext_sync[1:0], ext_irq3_pin};
         if (ext_sync[1] == ext_sync[2]) ext_level <= ext_sync[2];
         ext_level_d <= ext_level;
      end
   end
   dmaeis_sync_evt_t evt;
   always_comb begin
      evt      = sync_events;
      evt.ext3 = ext_level & ~ext_level_d;  // rising edge paces one transfer
   end

   // ---------------------------------------------------------------
   // per channel counting and interrupt timing
   // ---------------------------------------------------------------
   logic [15:0] next_ec [NUM_CH];
   logic [7:0]  next_fc [NUM_CH];
   logic [5:0]  irq_cond;
   genvar c;
   for (c = 0; c < NUM_CH; c++) begin : g_ch
      localparam int B = c * REGS_PER_CH;
      wire logic [15:0] ec     = sub[B + SUB_ECOUNT];
      wire logic [7:0]  fc     = sub[B + SUB_SYNC_FC][SFC_FRAME_LSB +: 8];
      wire logic        auto_buffer_mode    = sub[B + SUB_MODE][MODE_ABU_BIT];
      wire logic        ien    = sub[B + SUB_MODE][MODE_IEN_BIT];
      wire logic        itim   = sub[B + SUB_MODE][MODE_ITIM_BIT];
      wire logic [15:0] ec_dec = ec - 16'h0001;
      wire logic [15:0] half   = {1'b0, len[c][15:1]};
      wire logic        fr_end = xfer_read[c] & (ec_dec == 16'h0000);
      wire logic        blk    = fr_end & (auto_buffer_mode | (fc == 8'h00));
      wire logic        hbuf   = xfer_read[c] & auto_buffer_mode & (half != 16'h0000) & (ec_dec == half);
      // abu and every frame but the last reload; the last frame's end is the block end and holds zero
      assign next_ec[c]  = (fr_end && (auto_buffer_mode || fc != 8'h00)) ? len[c] : ec_dec;
      assign next_fc[c]  = (fr_end && !auto_buffer_mode && fc != 8'h00) ? fc - 8'h01 : fc;
      assign irq_cond[c] = ien & (auto_buffer_mode ? (blk | (itim & hbuf))
                                      : (itim ? fr_end : blk));
      dmaeis_sync_select u_sync (
         .clock    (clock),
         .srst     (srst),
         .sel      (sub[B + SUB_SYNC_FC][SFC_SYNC_LSB +: 4]),
         .events   (evt),
         .sync_req (sync_req[c])
      );
   end

   // software writes win over a transfer's count update in the same cycle
   always_ff @(posedge clock) begin
      for (int i = 0; i < NUM_SUB; i++) begin
         if (srst) sub[i] <= SUB_RESET;
         else if (sub_wr && sub_idx == 5'(i)) sub[i] <= mmr_wdata;
         else if (i % REGS_PER_CH == SUB_ECOUNT && xfer_read[i / REGS_PER_CH])
            sub[i] <= next_ec[i / REGS_PER_CH];
         else if (i % REGS_PER_CH == SUB_SYNC_FC && xfer_read[i / REGS_PER_CH])
            sub[i][7:0] <= next_fc[i / REGS_PER_CH];
      end
   end
   always_ff @(posedge clock) begin
      for (int k = 0; k < NUM_CH; k++) begin
         if (srst) len[k] <= SUB_RESET;
         else if (sub_wr && sub_idx == 5'(k * REGS_PER_CH + SUB_ECOUNT)) len[k] <= mmr_wdata;
      end
   end

   // ---------------------------------------------------------------
   // interrupt pulses and routing
   // ---------------------------------------------------------------
   dmaeis_cpu_line_t next_lines;
   always_comb begin
      next_lines = {port_irqs.p2_rx, port_irqs.p2_tx, port_irqs.p1_rx, port_irqs.p1_tx};
      // reserved code 11 behaves like reset routing
      if (route == ROUTE_CH23) begin
         next_lines.line10 = chan_irq[2];
         next_lines.line11 = chan_irq[3];
      end else if (route == ROUTE_CH0123) begin
         next_lines = {chan_irq[0], chan_irq[1], chan_irq[2], chan_irq[3]};
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         chan_irq  <= 6'h00;
         cpu_lines <= '0;
      end else begin
         chan_irq  <= irq_cond;
         cpu_lines <= next_lines;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   wire logic [15:0] ec0   = sub[SUB_ECOUNT];
   wire logic [7:0]  fc0   = sub[SUB_SYNC_FC][7:0];
   wire logic [15:0] mode0 = sub[SUB_MODE];
   wire logic        hw0   = xfer_read[0] & ~sub_wr;
   property p_ien_off;
      @(posedge clock) disable iff (srst) !mode0[MODE_IEN_BIT] |=> !chan_irq[0];
   endproperty
   a_ien_off: assert property (p_ien_off) else $error("irq with enable clear");
   property p_abu_full;
      @(posedge clock) disable iff (srst)
         hw0 && mode0[MODE_ABU_BIT] && mode0[MODE_IEN_BIT] && ec0 == 16'h0001 |=> chan_irq[0];
   endproperty
   a_abu_full: assert property (p_abu_full) else $error("no full buffer irq");
   property p_mf_block;
      @(posedge clock) disable iff (srst)
         hw0 && !mode0[MODE_ABU_BIT] && mode0[MODE_IEN_BIT] && !mode0[MODE_ITIM_BIT]
         && ec0 == 16'h0001 |=> chan_irq[0] == ($past(fc0) == 8'h00);
   endproperty
   a_mf_block: assert property (p_mf_block) else $error("block irq wrong");
   property p_mf_frame;
      @(posedge clock) disable iff (srst)
         hw0 && !mode0[MODE_ABU_BIT] && mode0[MODE_IEN_BIT] && mode0[MODE_ITIM_BIT]
         && ec0 == 16'h0001 |=> chan_irq[0];
   endproperty
   a_mf_frame: assert property (p_mf_frame) else $error("no frame end irq");
   property p_route_ports;
      @(posedge clock) disable iff (srst)
         route == ROUTE_PORTS |=> cpu_lines.line10 == $past(port_irqs.p1_rx);
   endproperty
   a_route_ports: assert property (p_route_ports) else $error("line 10 not port1 rx");
   property p_route_ch23;
      @(posedge clock) disable iff (srst)
         route == ROUTE_CH23 |=> cpu_lines.line11 == $past(chan_irq[3])
                                 && cpu_lines.line6 == $past(port_irqs.p2_rx);
   endproperty
   a_route_ch23: assert property (p_route_ch23) else $error("routing 01 wrong");
   property p_route_all;
      @(posedge clock) disable iff (srst)
         route == ROUTE_CH0123 |=> cpu_lines.line6 == $past(chan_irq[0]);
   endproperty
   a_route_all: assert property (p_route_all) else $error("line 6 not channel 0");
   property p_ptr_inc;
      @(posedge clock) disable iff (srst)
         mmr_rd && hit_inc |=> sub_ptr == $past(sub_ptr) + 16'h0001;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not incremented");
   property p_ptr_hold;
      @(posedge clock) disable iff (srst) (mmr_rd || mmr_wr) && hit_plain |=> $stable(sub_ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("plain port moved pointer");
   property p_ec_dec;
      @(posedge clock) disable iff (srst)
         hw0 && ec0 > 16'h0001 |=> ec0 == $past(ec0) - 16'h0001;
   endproperty
   a_ec_dec: assert property (p_ec_dec) else $error("element count not decremented");
   property p_ptr_read;
      @(posedge clock) disable iff (srst) mmr_rd && hit_ptr |=> mmr_rdata == $past(sub_ptr);
   endproperty
   a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong");
endmodule : dmaeis_top

// ==== verif/dmaeis_far_side.sv ====
// Purpose: far side model, event sources and cpu interrupt flag latch
// Assumes: bench commands are one-clock pulses taken after the rising edge
// Notes:   the ext3 struct field is unused by the block, so it toggles
`timescale 1ns/1ns
module dmaeis_far_side
   import dmaeis_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire dmaeis_sync_evt_t evt_cmd,
   input  wire dmaeis_port_irq_t irq_cmd,
   input  wire logic             ext_cmd,
   input  wire dmaeis_cpu_line_t cpu_lines,
   output dmaeis_sync_evt_t      sync_events,
   output dmaeis_port_irq_t      port_irqs,
   output logic                  ext_irq3_pin,
   output dmaeis_cpu_line_t      cpu_irq_flags
);
   // ---------------------------------------------------------------
   // event pulses, pin hold and sticky flags
   // ---------------------------------------------------------------
   logic [1:0] pin_hold;
   logic       junk;
   always_ff @(posedge clock) begin
      if (srst) begin
         sync_events   <= '0;
         port_irqs     <= '0;
         pin_hold      <= 2'h0;
         junk          <= 1'b0;
         cpu_irq_flags <= '0;
      end else begin
         sync_events   <= {evt_cmd[7:1], junk};
         port_irqs     <= irq_cmd;
         pin_hold      <= ext_cmd ? 2'h3 : (pin_hold == 2'h0 ? 2'h0 : pin_hold - 2'h1);
         junk          <= ~junk;
         cpu_irq_flags <= dmaeis_cpu_line_t'(cpu_irq_flags | cpu_lines);
      end
   end
   // a held level, so only its rising edge may count as an event
   assign ext_irq3_pin = (pin_hold != 2'h0);
endmodule : dmaeis_far_side

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the dma event and interrupt select block
// Assumes: one idle cycle between register accesses
// Notes:   results are matched in order against per-kind expectation queues
`timescale 1ns/1ns
module testbench
   import dmaeis_pkg::*;
;
   localparam logic [15:0] A_PREC = {8'h00, OFF_PRIO_EN};
   localparam logic [15:0] A_PTR  = {8'h00, OFF_SUB_PTR};
   localparam logic [15:0] A_INC  = {8'h00, OFF_SUB_INC};
   localparam logic [15:0] A_PLN  = {8'h00, OFF_SUB_PLAIN};
   logic             clock, srst, mmr_rd, mmr_wr, ext_cmd, ext_irq3_pin, rd_d;
   logic [15:0]      mmr_addr, mmr_wdata, mmr_rdata, d, v;
   logic [5:0]       xfer_read, sync_req, chan_irq, chan_enable, chan_high_prio;
   logic [3:0]       x;
   dmaeis_sync_evt_t evt_cmd, sync_events;
   dmaeis_port_irq_t irq_cmd, port_irqs;
   dmaeis_cpu_line_t cpu_lines, cpu_irq_flags;
   logic [15:0]      q_rd[$];
   logic [5:0]       q_irq[$], q_sync[$];
   logic [3:0]       q_cpu[$];
   logic [3:0]       codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hD, 4'hE};
   int               err_count, comparisons, seed, c;
   dmaeis_top #(.ADDR_W(16)) i_dmaeis_top (
      .clock(clock), .srst(srst), .mmr_addr(mmr_addr), .mmr_rd(mmr_rd), .mmr_wr(mmr_wr),
      .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata), .sync_events(sync_events),
      .ext_irq3_pin(ext_irq3_pin), .xfer_read(xfer_read), .port_irqs(port_irqs),
      .sync_req(sync_req), .chan_irq(chan_irq), .cpu_lines(cpu_lines),
      .chan_enable(chan_enable), .chan_high_prio(chan_high_prio));
   dmaeis_far_side i_dmaeis_far_side (
      .clock(clock), .srst(srst), .evt_cmd(evt_cmd), .irq_cmd(irq_cmd), .ext_cmd(ext_cmd),
      .cpu_lines(cpu_lines), .sync_events(sync_events), .port_irqs(port_irqs),
      .ext_irq3_pin(ext_irq3_pin), .cpu_irq_flags(cpu_irq_flags));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // ---------------------------------------------------------------
   // drivers, comparisons and closing
   // ---------------------------------------------------------------
   task tick;
      @(posedge clock);
      #1;
   endtask : tick
   task automatic acc(input logic r, w, input logic [15:0] a, dat);
      mmr_rd = r;
      mmr_wr = w;
      mmr_addr = a;
      mmr_wdata = dat;
      tick;
      mmr_rd = 1'b0;
      mmr_wr = 1'b0;
      tick;
   endtask : acc
   task automatic wr(input logic [15:0] a, dat);
      acc(1'b0, 1'b1, a, dat);
   endtask : wr
   task automatic rd(input logic [15:0] a, e);
      q_rd.push_back(e);
      acc(1'b1, 1'b0, a, 16'h0000);
   endtask : rd
   task automatic sub_wr(input int i, input logic [15:0] dat);
      wr(A_PTR, 16'(i));
      wr(A_PLN, dat);
   endtask : sub_wr
   task automatic pulse_read(input logic [5:0] m);
      xfer_read = m;
      tick;
      xfer_read = 6'h00;
      tick;
   endtask : pulse_read
   task automatic check_en(input logic [15:0] e);
      tally(1'b1, e, {2'h0, chan_high_prio, 2'h0, chan_enable});
   endtask : check_en
   task automatic tally(input bit ok, input logic [15:0] e, g);
      comparisons++;
      if (!ok || e !== g) begin
         err_count++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask : tally
   task automatic check_rd(input logic [15:0] g);
      bit ok;
      ok = q_rd.size() != 0;
      tally(ok, ok ? q_rd.pop_front() : 16'h0000, g);
   endtask : check_rd
   task automatic check_irq(input logic [5:0] g);
      bit ok;
      ok = q_irq.size() != 0;
      tally(ok, ok ? 16'(q_irq.pop_front()) : 16'h0000, 16'(g));
   endtask : check_irq
   task automatic check_sync(input logic [5:0] g);
      bit ok;
      ok = q_sync.size() != 0;
      tally(ok, ok ? 16'(q_sync.pop_front()) : 16'h0000, 16'(g));
   endtask : check_sync
   task automatic check_cpu(input logic [3:0] g);
      bit ok;
      ok = q_cpu.size() != 0;
      tally(ok, ok ? 16'(q_cpu.pop_front()) : 16'h0000, 16'(g));
   endtask : check_cpu
   task automatic run(input int ch, input logic [15:0] mode, ec, fc, input int nrd, nirq,
                      input logic [15:0] ec_end);
      sub_wr(ch * 5 + 2, ec);
      sub_wr(ch * 5 + 3, fc);
      sub_wr(ch * 5 + 4, mode);
      repeat (nirq) q_irq.push_back(6'h01 << ch);
      repeat (nrd) pulse_read(6'h01 << ch);
      wr(A_PTR, 16'(ch * 5 + 2));
      rd(A_PLN, ec_end);
      $display("test irq mode %h over", mode);
   endtask : run
   task report_and_stop;
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   // a result appears: take the oldest note of that kind and compare
   always @(posedge clock) begin
      rd_d <= mmr_rd;
      if (rd_d) check_rd(mmr_rdata);
      if (chan_irq !== 6'h00) check_irq(chan_irq);
      if (sync_req !== 6'h00) check_sync(sync_req);
      if (cpu_lines !== 4'h0) check_cpu(cpu_lines);
   end
   initial begin
      repeat (30000) @(posedge clock);
      err_count++;
      report_and_stop;
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {srst, mmr_rd, mmr_wr, ext_cmd} = 4'h8;
      {mmr_addr, mmr_wdata, xfer_read} = '0;
      evt_cmd = '0;
      irq_cmd = '0;
      err_count = 0;
      comparisons = 0;
      seed = 1;
      repeat (20) @(posedge clock);
      #1;
      srst = 1'b0;
      rd(A_PREC, 16'h0000);
      wr(16'h0154, 16'hFFFF);
      rd(A_PREC, 16'h0000);
      rd(16'h0058, 16'h0000);
      rd(A_PLN, SUB_RESET);
      d = 16'($random(seed));
      // address words only, so no channel starts pacing on stray events
      wr(A_PTR, 16'h0000);
      wr(A_INC, d);
      rd(A_PTR, 16'h0001);
      wr(A_PLN, ~d);
      rd(A_PTR, 16'h0001);
      rd(A_PLN, ~d);
      wr(A_PTR, 16'h0000);
      rd(A_INC, d);
      rd(A_PTR, 16'h0001);
      $display("test registers over");
      c = {$random(seed)} % 6;
      foreach (codes[k]) begin
         sub_wr(c * 5 + 3, {codes[k], 12'h000});
         for (int i = 0; i < 7; i++) begin
            if (codes[k] == (i < 6 ? i + 1 : 13)) q_sync.push_back(6'h01 << c);
            evt_cmd = dmaeis_sync_evt_t'(8'h80 >> i);
            tick;
            evt_cmd = '0;
            tick;
         end
         if (codes[k] == 4'hE) q_sync.push_back(6'h01 << c);
         ext_cmd = 1'b1;
         tick;
         ext_cmd = 1'b0;
         repeat (10) tick;
      end
      $display("test sync select over");
      for (int ch = 0; ch < 6; ch++) run(ch, 16'h7000, 16'h0002, 16'h0000, 2, 2, 16'h0002);
      d = 16'(2 * ({$random(seed)} % 8 + 1));
      run(c, 16'h7000, d, 16'h0000, int'(d), 2, d);
      run(c, 16'h3000, 16'h0004, 16'h0000, 4, 1, 16'h0004);
      run(c, 16'h5000, 16'h0002, 16'h0000, 4, 0, 16'h0002);
      run(c, 16'h2000, 16'h0002, 16'h0001, 4, 1, 16'h0000);
      run(c, 16'h6000, 16'h0002, 16'h0001, 4, 2, 16'h0000);
      run(c, 16'h4000, 16'h0002, 16'h0001, 4, 0, 16'h0000);
      run(0, 16'h2000, 16'h0002, 16'h0001, 4, 1, 16'h0000);
      run(0, 16'h6000, 16'h0002, 16'h0001, 4, 2, 16'h0000);
      for (int ch = 0; ch < 4; ch++) run(ch, 16'h3000, 16'h0001, 16'h0000, 0, 0, 16'h0001);
      // routing code 11 is reserved and is never written
      for (int r = 0; r < 3; r++) begin
         v = {2'(r), 14'($random(seed))};
         wr(A_PREC, v);
         rd(A_PREC, v);
         check_en({2'h0, v[13:8], 2'h0, v[5:0]});
         x = (r == 0) ? 4'hF : (r == 1) ? 4'hC : 4'h0;
         if (x != 4'h0) q_cpu.push_back(x);
         irq_cmd = dmaeis_port_irq_t'(4'hF);
         tick;
         irq_cmd = '0;
         repeat (4) tick;
         x = (r == 0) ? 4'h0 : (r == 1) ? 4'h3 : 4'hF;
         if (x != 4'h0) q_cpu.push_back(x);
         q_irq.push_back(6'h0F);
         pulse_read(6'h0F);
         repeat (4) tick;
      end
      $display("test routing over");
      repeat (10) tick;
      tally(1'b1, 16'h000F, 16'(cpu_irq_flags));
      tally(q_rd.size() + q_irq.size() + q_sync.size() + q_cpu.size() == 0,
            16'h0000, 16'h0000);
      report_and_stop;
   end
endmodule : testbench
